// ### inc/bcgpf_pkg.sv
package bcgpf_pkg;

  // ==========================================================================
  // register map
  localparam logic [15:0] GP_FLAG_REG_ADDR = 16'h0037;
  localparam logic [15:0] CC_REG_ADDR      = 16'h0037;
  localparam logic [15:0] FLAG_RESET       = 16'h0000;

  // ==========================================================================
  // condition code field
  localparam int          CC_SEL_MSB    = 3;
  localparam int          CC_SENSE_BIT  = 4;
  localparam logic [3:0]  CC_FLAG_ONE   = 4'h1;
  localparam logic [3:0]  CC_FLAG_FIRST = 4'h2;
  localparam logic [3:0]  CC_FLAG_LAST  = 4'h5;
  localparam int          FLAG_LO       = 1;
  localparam int          FLAG_HI       = 5;

  // ==========================================================================
  // flag register word: high byte clears, low byte sets, both toggles
  localparam int          CLR_BASE      = 8;
  localparam int          SET_BASE      = 0;

  typedef enum logic [1:0] {
    BCGPF_CMP_NONE = 2'b00,
    BCGPF_CMP_MSG  = 2'b01,
    BCGPF_CMP_FRM  = 2'b11
  } bcgpf_cmp_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] word;
  } bcgpf_flag_cmd_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] param;
  } bcgpf_cmp_cmd_t;

endpackage : bcgpf_pkg

// ### rtl/bcgpf_core.sv
// Behaviour
// - code 1 tests flag one; sense bit 1 tests not-equal (inverse)
// - flag one set/clear/toggle by flag op and host register write
// - compare timer op codes also update flag one from compare result
// - compare parameter below timer value clears flag one
// - compare parameter equal to timer value sets flag one
// - compare parameter above timer value clears flag one
// - codes 2 to 5 select flags two to five, either sense
// - flags two to five change by flag op or host write only
// - low four code bits pick condition; bit four picks required outcome
// - host reads condition code values read-only through register
`timescale 1ns/1ps
`default_nettype none

module bcgpf_core
  import bcgpf_pkg::*;
(
  // clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       arst_n,
  // host register port
  input  wire logic                       host_wr,
  input  wire logic                       host_rd,
  input  wire logic [15:0]                host_addr,
  input  wire logic [15:0]                host_wdata,
  output logic      [15:0]                host_rdata,
  // sequencer op codes
  input  wire bcgpf_pkg::bcgpf_flag_cmd_t flag_manipulate_op,
  input  wire bcgpf_pkg::bcgpf_cmp_cmd_t  compare_message_timer_op,
  input  wire bcgpf_pkg::bcgpf_cmp_cmd_t  compare_frame_timer_op,
  // timer values
  input  wire logic [15:0]                time_to_next_msg,
  input  wire logic [15:0]                frame_time_remaining,
  // condition evaluation
  input  wire logic [4:0]                 cond_code,
  input  wire logic [7:0]                 msg_cond_flags,
  output logic                            cond_met,
  output logic                            equal_condition,
  output logic                            not_equal_condition
);

  import bcgpf_pkg::*;

  // ==========================================================================
  // decode
  logic        host_flag_wr;
  logic        host_cc_rd;
  logic        cmp_load;
  logic [15:0] cmp_param;
  logic [15:0] cmp_timer;
  logic        cmp_val;
  logic [7:0]  flags;
  logic [15:0] cc_word;

  function automatic logic cc_lookup(input logic [3:0] sel,
                                     input logic [15:0] word);
    cc_lookup = word[sel];
  endfunction : cc_lookup

  assign host_flag_wr = host_wr && (host_addr == GP_FLAG_REG_ADDR);
  assign host_cc_rd   = host_rd && (host_addr == CC_REG_ADDR);
  assign cmp_load     = compare_message_timer_op.valid |
                        compare_frame_timer_op.valid;
  assign cmp_param    = compare_message_timer_op.valid ?
                        compare_message_timer_op.param :
                        compare_frame_timer_op.param;
  assign cmp_timer    = compare_message_timer_op.valid ?
                        time_to_next_msg : frame_time_remaining;
  // only equality sets; less and greater both clear
  assign cmp_val      = (cmp_param == cmp_timer);

  // ==========================================================================
  // flag cells; only flag one sees compare loads
  assign flags[0] = 1'b0;
  assign flags[6] = 1'b0;
  assign flags[7] = 1'b0;

  genvar gi;
  generate
    for (gi = FLAG_LO; gi <= FLAG_HI; gi++) begin : g_flag
      bcgpf_flag_cell u_cell (
        .ref_clk  (ref_clk),
        .arst_n   (arst_n),
        .op_set   (flag_manipulate_op.valid &
                   flag_manipulate_op.word[SET_BASE + gi]),
        .op_clr   (flag_manipulate_op.valid &
                   flag_manipulate_op.word[CLR_BASE + gi]),
        .cmp_load ((gi == FLAG_LO) ? cmp_load : 1'b0),
        .cmp_val  (cmp_val),
        .host_set (host_flag_wr & host_wdata[SET_BASE + gi]),
        .host_clr (host_flag_wr & host_wdata[CLR_BASE + gi]),
        .flag_r   (flags[gi])
      );
    end
  endgenerate

  // ==========================================================================
  // condition word: low byte general flags, high byte message outcome
  assign cc_word = {msg_cond_flags, flags};

  logic        cond_true;
  logic        cond_met_nxt;
  logic [15:0] rdata_nxt;

  assign cond_true    = cc_lookup(cond_code[CC_SEL_MSB:0], cc_word);
  // sense bit selects inverse outcome
  assign cond_met_nxt = cond_true ^ cond_code[CC_SENSE_BIT];
  // read-only: writes to this address go to the flag register instead
  assign rdata_nxt    = host_cc_rd ? cc_word : host_rdata;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      host_rdata          <= FLAG_RESET;
      cond_met            <= 1'b0;
      equal_condition     <= 1'b0;
      not_equal_condition <= 1'b1;
    end else begin
      host_rdata          <= rdata_nxt;
      cond_met            <= cond_met_nxt;
      equal_condition     <= flags[FLAG_LO];
      not_equal_condition <= ~flags[FLAG_LO];
    end
  end

endmodule : bcgpf_core

`default_nettype wire

// ### rtl/bcgpf_flag_cell.sv
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// one flag bit: set/clear/toggle from op code, then compare, then host write
module bcgpf_flag_cell (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic arst_n,
  // op code action
  input  wire logic op_set,
  input  wire logic op_clr,
  // compare load
  input  wire logic cmp_load,
  input  wire logic cmp_val,
  // host action
  input  wire logic host_set,
  input  wire logic host_clr,
  // state
  output logic      flag_r
);

  logic op_nxt;
  logic cmp_nxt;
  logic flag_nxt;

  // set and clear together toggle
  assign op_nxt   = (op_set & op_clr) ? ~flag_r :
                    op_set ? 1'b1 : op_clr ? 1'b0 : flag_r;
  assign cmp_nxt  = cmp_load ? cmp_val : op_nxt;
  // host write applied last so it wins
  assign flag_nxt = (host_set & host_clr) ? ~cmp_nxt :
                    host_set ? 1'b1 : host_clr ? 1'b0 : cmp_nxt;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

endmodule : bcgpf_flag_cell

`default_nettype wire

// ### verif/bcgpf_core_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// port checker for the flag core
module bcgpf_chk
  import bcgpf_pkg::*;
(
  // clock and reset
  input wire logic                      ref_clk,
  input wire logic                      arst_n,
  // requests
  input wire logic                      host_wr,
  input wire logic [15:0]               host_addr,
  input wire logic [15:0]               host_wdata,
  input wire bcgpf_pkg::bcgpf_cmp_cmd_t compare_message_timer_op,
  input wire bcgpf_pkg::bcgpf_cmp_cmd_t compare_frame_timer_op,
  input wire logic [15:0]               time_to_next_msg,
  input wire logic [15:0]               frame_time_remaining,
  input wire logic [4:0]                cond_code,
  // results
  input wire logic                      cond_met,
  input wire logic                      equal_condition,
  input wire logic                      not_equal_condition
);
  wire hit = host_wr && host_addr == 16'h0037;
  wire sense = cond_code[4];
  wire f_eq = compare_frame_timer_op.param == frame_time_remaining;
  wire m_go = compare_message_timer_op.valid && !hit;
  wire m_eq = compare_message_timer_op.param == time_to_next_msg;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  a_sense_pair: assert property (equal_condition ^ not_equal_condition)
    else $error("eq and ne not inverse");
  a_host_set: assert property (hit && host_wdata[1] && !host_wdata[9]
    |=> ##1 equal_condition) else $error("host set lost");
  a_host_clr: assert property (hit && !host_wdata[1] && host_wdata[9]
    |=> ##1 !equal_condition) else $error("host clear lost");
  a_msg_equal: assert property (m_go && m_eq |=> ##1 equal_condition)
    else $error("equal compare did not set");
  a_msg_differ: assert property (m_go && !m_eq |=> ##1 !equal_condition)
    else $error("unequal compare did not clear");
  a_frame_cmp: assert property (compare_frame_timer_op.valid
    && !compare_message_timer_op.valid && !hit
    |=> ##1 equal_condition == $past(f_eq, 2)) else $error("frame compare");
  a_cond_flag: assert property (cond_code[3:0] == 4'h1
    |=> cond_met == (equal_condition ^ $past(sense))) else $error("code one");
  a_code_unused: assert property (cond_code[3:0] inside {4'h0, 4'h6, 4'h7}
    |=> cond_met == $past(sense)) else $error("unused code");
endmodule : bcgpf_chk
bind bcgpf_core bcgpf_chk bcgpf_chk_i (.ref_clk, .arst_n, .host_wr, .host_addr,
  .host_wdata, .compare_message_timer_op, .compare_frame_timer_op,
  .time_to_next_msg, .frame_time_remaining, .cond_code, .cond_met,
  .equal_condition, .not_equal_condition);
`default_nettype wire

// ### verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import bcgpf_pkg::*;
  logic            ref_clk = 0, arst_n = 0, host_wr = 0, host_rd = 0;
  logic [15:0]     host_addr = 16'h0037, host_wdata = '0, host_rdata;
  logic [15:0]     time_to_next_msg = 16'h0100, frame_time_remaining = 16'h0080;
  logic [7:0]      msg_cond_flags = 8'hA5;
  logic [4:0]      cond_code = '0;
  logic            cond_met, equal_condition, not_equal_condition;
  bcgpf_flag_cmd_t flag_manipulate_op = '0;
  bcgpf_cmp_cmd_t  compare_message_timer_op = '0, compare_frame_timer_op = '0;
  int              err_count = 0, checked = 0, cycles = 0;
  bcgpf_core bcgpf_core_i (.ref_clk, .arst_n, .host_wr, .host_rd, .host_addr,
    .host_wdata, .host_rdata, .flag_manipulate_op, .compare_message_timer_op,
    .compare_frame_timer_op, .time_to_next_msg, .frame_time_remaining,
    .cond_code, .msg_cond_flags, .cond_met, .equal_condition,
    .not_equal_condition);
  always #25 ref_clk = ~ref_clk;
  // ==========================================
  // shared tasks
  task automatic chk(input logic [15:0] s, e, input string n);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic go(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : go
  task automatic wr(input logic [15:0] a, d);
    host_addr = a;
    host_wdata = d;
    host_wr = 1;
    go(1);
    host_wr = 0;
  endtask : wr
  task automatic rd(input logic [7:0] e);
    host_addr = 16'h0037;
    host_rd = 1;
    go(1);
    host_rd = 0;
    go(1);
    chk(host_rdata, {8'hA5, e}, "rdata");
  endtask : rd
  task automatic eqc(input logic e);
    go(1);
    chk(equal_condition, e, "eq");
    chk(not_equal_condition, !e, "ne");
  endtask : eqc
  task automatic op(input logic [15:0] w);
    flag_manipulate_op = '{1'b1, w};
    go(1);
    flag_manipulate_op = '0;
  endtask : op
  task automatic cmp(input logic f, input logic [15:0] p, input logic e);
    if (f) compare_frame_timer_op = '{1'b1, p};
    else compare_message_timer_op = '{1'b1, p};
    go(1);
    compare_frame_timer_op = '0;
    compare_message_timer_op = '0;
    eqc(e);
  endtask : cmp
  // ==========================================
  // scenarios
  task automatic t_host;
    chk(host_rdata, 16'h0000, "rdata reset");
    wr(16'h0037, 16'h0002);
    eqc(1);
    wr(16'h0037, 16'h0202);
    eqc(0);
    wr(16'h0036, 16'h0002);
    eqc(0);
  endtask : t_host
  task automatic t_flags;
    wr(16'h0037, 16'h00FF);
    rd(8'h3E);
    op(16'h3C3C);
    rd(8'h02);
    op(16'h0014);
    rd(8'h16);
  endtask : t_flags
  task automatic t_cmp;
    cmp(0, 16'h00FF, 0);
    cmp(0, 16'h0100, 1);
    cmp(0, 16'h0101, 0);
    cmp(1, 16'h0080, 1);
    cmp(1, 16'h007F, 0);
    rd(8'h14);
  endtask : t_cmp
  task automatic t_prio;
    flag_manipulate_op = '{1'b1, 16'h0002};
    wr(16'h0037, 16'h0200);
    flag_manipulate_op = '0;
    eqc(0);
  endtask : t_prio
  task automatic t_cc;
    for (int c = 0; c < 32; c++) begin
      cond_code = c[4:0];
      go(2);
      chk(cond_met, 16'hA514 >> c[3:0] & 1 ^ c[4], "cond_met");
    end
  endtask : t_cc
  task automatic summarize;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      summarize();
    end
  end
  initial begin
    go(4);
    arst_n = 1;
    t_host();
    t_flags();
    t_cmp();
    t_prio();
    t_cc();
    summarize();
  end
endmodule : tb
`default_nettype wire
